// file: pkg/wdr_pkg.sv
// Constants and types for the watchdog reset timer
package wdr_pkg;
  localparam int unsigned TICK_DIV      = 64;
  localparam int unsigned TICK_W        = 6;
  localparam logic [5:0]  TICK_LAST     = 6'(TICK_DIV - 1);
  localparam int unsigned CNT_W         = 16;
  localparam logic [15:0] CNT_ONE       = 16'h0001;
  localparam logic [15:0] CNT_MAX       = 16'hFFFF;
  localparam logic [15:0] RESTART_VEC   = 16'h0020;
  localparam logic [15:0] VEC_RST       = 16'h0000;
  localparam int unsigned SEL_W         = 3;
  localparam logic [2:0]  SEL_MAX       = 3'h7;
  localparam int unsigned SEL_BASE      = 9;
  // Register indices as printed; the byte address is four times the index
  localparam logic [7:0]  IDX_CNT_LO    = 8'hC2;
  localparam logic [7:0]  IDX_CNT_HI    = 8'hC3;
  localparam logic [7:0]  IDX_CTRL      = 8'h00;
  localparam logic [7:0]  IDX_STATUS    = 8'h01;
  localparam logic [7:0]  IDX_CMD       = 8'h02;
  localparam int unsigned IDX_LSB       = 2;
  localparam int unsigned IDX_MSB       = 9;
  // Control word fields
  localparam int unsigned CTRL_DIS_BIT  = 0;
  localparam int unsigned CTRL_SEL_LSB  = 4;
  // Status word fields
  localparam int unsigned ST_TMO_BIT    = 0;
  localparam int unsigned ST_STOP_BIT   = 1;
  localparam int unsigned ST_LOCK_BIT   = 2;
  localparam int unsigned ST_RUN_BIT    = 3;
  localparam int unsigned ST_HALT_BIT   = 4;
  // Command word fields
  localparam int unsigned CMD_REFR_BIT  = 0;
  localparam int unsigned CMD_STOP_BIT  = 1;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] WORD_ZERO     = 32'h00000000;
  localparam logic        HRESP_OKAY    = 1'b0;

  typedef enum logic [1:0] {
    WDR_RUN  = 2'h0,
    WDR_STOP = 2'h1,
    WDR_OFF  = 2'h3
  } wdr_state_t;

  // Initial count for a timeout selection; the top code gives all ones
  function automatic logic [15:0] wdr_reload(input logic [2:0] sel);
    logic [31:0] ones;
    ones = ~(32'hFFFFFFFF << (SEL_BASE + 32'(sel)));
    return ones[15:0];
  endfunction : wdr_reload
endpackage : wdr_pkg

// file: pkg/wdr_tick_if.sv
// Carrier for the prescaler enable and its tick
`timescale 1ns/1ns
interface wdr_tick_if;
  logic enable;
  logic tick;
  modport pre  (input enable, output tick);
  modport core (output enable, input tick);
endinterface : wdr_tick_if

// file: design/wdr_prescaler.sv
// Divide-by-64 tick generator for the watchdog counter
`timescale 1ns/1ns
module wdr_prescaler
  import wdr_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  wdr_tick_if.pre   tk
);
  logic [TICK_W-1:0] div_r;
  logic [TICK_W-1:0] div_nxt;
  logic              last;

  assign last    = (div_r == TICK_LAST);
  // Idle count restarts from zero so a resume always waits a full period
  assign div_nxt = !tk.enable ? '0 : (last ? '0 : div_r + 1'b1);
  assign tk.tick = tk.enable & last;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end
endmodule : wdr_prescaler

// file: design/wdr_watchdog.sv
// Watchdog reset timer with AHB-Lite register slave
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
module wdr_watchdog
  import wdr_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ext_reset_pin_n,
  input  wire logic        wake_pin,
  input  wire logic        halt_mode,
  output logic             wdt_reset,
  output logic             vector_load,
  output logic [15:0]      restart_vector,
  output logic             stop_mode
);
  import wdr_pkg::*;

  // Bus address and data phase state
  logic        ap_wr_r;
  logic [7:0]  ap_idx_r;
  logic        rd_pend_r;
  logic        rdy_r;
  logic [31:0] rdata_r;
  logic        take;
  logic        take_rd;
  logic        take_wr;
  logic [7:0]  idx_now;
  logic [31:0] rd_mux;

  // Synchronisers for pins
  logic [2:0]  rstp_sync_r;
  logic [2:0]  wake_sync_r;
  logic        pin_rst_r;
  logic        pin_rst_nxt;
  logic        wake_r;
  logic        wake_nxt;

  // Watchdog state
  wdr_state_t  state_r;
  wdr_state_t  state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [2:0]  sel_r;
  logic [2:0]  sel_nxt;
  logic        dis_r;
  logic        lock_r;
  logic        tmo_flag_r;
  logic        tmo_flag_nxt;
  logic        stop_flag_r;
  logic        stop_flag_nxt;
  logic        rst_out_r;
  logic        vec_ld_r;
  logic [15:0] vec_r;
  logic        stop_mode_r;
  logic        hresp_r;

  // Write decode
  logic        wr_cnt_lo;
  logic        wr_cnt_hi;
  logic        wr_ctrl;
  logic        wr_status;
  logic        wr_cmd;
  logic        cmd_refresh;
  logic        cmd_stop;
  logic        tmo_clr;
  logic        stop_clr;
  logic        running;
  logic        timeout;

  wdr_tick_if tk ();

  wdr_prescaler u_pre (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tk      (tk.pre)
  );

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] reg_idx);
    return idx == reg_idx;
  endfunction : hit

  // Bus decode; reads take one wait state so that a write just before is visible
  assign take    = hsel & (htrans == HTRANS_NONSEQ) & hready & rdy_r;
  assign take_rd = take & !hwrite;
  assign take_wr = ap_wr_r;
  assign idx_now = haddr[IDX_MSB:IDX_LSB];

  assign wr_cnt_lo = take_wr & hit(ap_idx_r, IDX_CNT_LO);
  assign wr_cnt_hi = take_wr & hit(ap_idx_r, IDX_CNT_HI);
  assign wr_ctrl   = take_wr & hit(ap_idx_r, IDX_CTRL) & !lock_r;
  assign wr_status = take_wr & hit(ap_idx_r, IDX_STATUS);
  assign wr_cmd    = take_wr & hit(ap_idx_r, IDX_CMD);

  assign cmd_refresh = wr_cmd & hwdata[CMD_REFR_BIT];
  assign cmd_stop    = wr_cmd & hwdata[CMD_STOP_BIT];
  // Write one to clear; a read has no side effect on any flag
  assign tmo_clr     = wr_status & hwdata[ST_TMO_BIT];
  assign stop_clr    = wr_status & hwdata[ST_STOP_BIT];

  assign rd_mux = hit(ap_idx_r, IDX_CNT_LO) ? {24'h000000, cnt_r[7:0]} :
                  hit(ap_idx_r, IDX_CNT_HI) ? {24'h000000, cnt_r[15:8]} :
                  hit(ap_idx_r, IDX_CTRL)   ? {25'h0000000, sel_r, 3'h0, dis_r} :
                  hit(ap_idx_r, IDX_STATUS) ? {27'h0000000, halt_mode, running, lock_r,
                                               stop_flag_r, tmo_flag_r} :
                  WORD_ZERO;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r   <= 1'b0;
      ap_idx_r  <= '0;
      rd_pend_r <= 1'b0;
      rdy_r     <= 1'b1;
      rdata_r   <= WORD_ZERO;
    end else begin
      ap_wr_r   <= take & hwrite;
      if (take) begin
        ap_idx_r <= idx_now;
      end
      rd_pend_r <= take_rd;
      rdy_r     <= !take_rd;
      if (rd_pend_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // Pins from outside pass three flops; a change counts when the last two agree
  assign pin_rst_nxt = (rstp_sync_r[1] == rstp_sync_r[2]) ? !rstp_sync_r[2] : pin_rst_r;
  assign wake_nxt    = (wake_sync_r[1] == wake_sync_r[2]) ? wake_sync_r[2] : wake_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rstp_sync_r <= 3'h7;
      wake_sync_r <= 3'h0;
      pin_rst_r   <= 1'b0;
      wake_r      <= 1'b0;
    end else begin
      rstp_sync_r <= {rstp_sync_r[1:0], ext_reset_pin_n};
      wake_sync_r <= {wake_sync_r[1:0], wake_pin};
      pin_rst_r   <= pin_rst_nxt;
      wake_r      <= wake_nxt;
    end
  end

  // Counter runs in run and halt; stop and a pre-lock disable freeze it
  assign running   = (state_r == WDR_RUN);
  assign tk.enable = running;
  // Reaching zero on a tick is the terminal count; a zero written by software also fires
  assign timeout   = running & tk.tick & (cnt_r <= CNT_ONE);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      WDR_RUN: begin
        if (wr_ctrl & hwdata[CTRL_DIS_BIT]) begin
          state_nxt = WDR_OFF;
        end else if (cmd_stop & !timeout) begin
          state_nxt = WDR_STOP;
        end
      end
      WDR_STOP: begin
        if (wake_r) begin
          state_nxt = WDR_RUN;
        end
      end
      WDR_OFF: begin
        state_nxt = WDR_OFF;
      end
      default: begin
        state_nxt = WDR_RUN;
      end
    endcase
  end

  assign sel_nxt = wr_ctrl ? hwdata[CTRL_SEL_LSB +: SEL_W] : sel_r;

  // Timeout reloads too, so a refresh in the same cycle changes nothing and the reset stands
  always_comb begin
    cnt_nxt = cnt_r;
    if (timeout | cmd_refresh) begin
      cnt_nxt = wdr_reload(sel_r);
    end else if (wr_cnt_lo) begin
      cnt_nxt = {cnt_r[15:8], hwdata[7:0]};
    end else if (wr_cnt_hi) begin
      cnt_nxt = {hwdata[7:0], cnt_r[7:0]};
    end else if (running & tk.tick) begin
      cnt_nxt = cnt_r - CNT_ONE;
    end
  end

  // Hardware set wins over both software clear and the reset pin
  assign tmo_flag_nxt  = timeout | (tmo_flag_r & !tmo_clr & !pin_rst_r);
  assign stop_flag_nxt = (cmd_stop & running & !timeout) |
                         (stop_flag_r & !stop_clr & !pin_rst_r);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r     <= WDR_RUN;
      cnt_r       <= CNT_MAX;
      sel_r       <= SEL_MAX;
      dis_r       <= 1'b0;
      lock_r      <= 1'b0;
      tmo_flag_r  <= 1'b0;
      stop_flag_r <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      sel_r       <= sel_nxt;
      if (wr_ctrl) begin
        dis_r <= hwdata[CTRL_DIS_BIT];
      end
      if (take_wr) begin
        lock_r <= 1'b1;
      end
      tmo_flag_r  <= tmo_flag_nxt;
      stop_flag_r <= stop_flag_nxt;
    end
  end

  // Restart outputs; reset and vector load are one-cycle pulses, the restart vector is held
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_out_r <= 1'b0;
      vec_ld_r  <= 1'b0;
      vec_r     <= VEC_RST;
      stop_mode_r <= 1'b0;
      hresp_r     <= HRESP_OKAY;
    end else begin
      // Taken from the next state so the pin moves with the state flop itself
      stop_mode_r <= (state_nxt == WDR_STOP);
      // Only OKAY is ever answered
      hresp_r     <= HRESP_OKAY;
      rst_out_r <= timeout;
      vec_ld_r  <= timeout;
      if (timeout) begin
        vec_r <= RESTART_VEC;
      end
    end
  end

  assign hrdata         = rdata_r;
  assign hreadyout      = rdy_r;
  assign hresp          = hresp_r;
  assign wdt_reset      = rst_out_r;
  assign vector_load    = vec_ld_r;
  assign restart_vector = vec_r;
  assign stop_mode      = stop_mode_r;

  logic unused_ok;
  assign unused_ok = &{1'b0, hsize, hwdata[31:8]};
endmodule : wdr_watchdog

// file: design/unused_placeholder_removed.sv
// Intentionally empty compile unit
`timescale 1ns/1ns

// file: tb/wdr_watchdog_chk.sv
// Concurrent checks on the watchdog reset timer ports
`timescale 1ns/1ns
module wdr_watchdog_chk
  import wdr_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        wdt_reset,
  input wire logic        vector_load,
  input wire logic [15:0] restart_vector,
  input wire logic        stop_mode
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       take;
  logic [6:0] gap_r;
  assign take = hsel && htrans == HTRANS_NONSEQ && hready && hreadyout;
  // Cycles since the last pulse; a tick every 64 clocks bounds how close two pulses can be
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) gap_r <= 7'h00;
    else if (wdt_reset) gap_r <= 7'h00;
    else if (gap_r != 7'h7F) gap_r <= gap_r + 7'h01;
  end
  property p_pair; wdt_reset |-> vector_load; endproperty
  a_pair: assert property (p_pair) else $error("reset pulse without vector load");
  property p_vec; vector_load |=> restart_vector == RESTART_VEC; endproperty
  a_vec: assert property (p_vec) else $error("restart vector wrong after timeout");
  property p_once; wdt_reset |=> !wdt_reset; endproperty
  a_once: assert property (p_once) else $error("reset pulse longer than one cycle");
  property p_gap; wdt_reset |-> gap_r >= 7'h3C; endproperty
  a_gap: assert property (p_gap) else $error("timeouts closer than one tick");
  property p_frz; stop_mode && $past(stop_mode) |-> !wdt_reset; endproperty
  a_frz: assert property (p_frz) else $error("timeout while stopped");
  property p_rdw; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rdw: assert property (p_rdw) else $error("read wait state wrong");
  property p_wrw; take && hwrite |=> hreadyout; endproperty
  a_wrw: assert property (p_wrw) else $error("write wait state inserted");
  // A timeout in the command's cycle refuses the stop and shows as a reset pulse instead
  property p_stp;
    take && hwrite && haddr[9:2] == IDX_CMD ##1 hwdata[CMD_STOP_BIT] |=> stop_mode || wdt_reset;
  endproperty
  a_stp: assert property (p_stp) else $error("stop command not obeyed");
  property p_ok; hresp == HRESP_OKAY; endproperty
  a_ok: assert property (p_ok) else $error("response not okay");
  c_tmo: cover property (wdt_reset);
  c_stop: cover property (stop_mode);
  c_read: cover property (take && !hwrite);
endmodule : wdr_watchdog_chk

bind wdr_watchdog wdr_watchdog_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .hresp, .wdt_reset, .vector_load, .restart_vector, .stop_mode);

// file: tb/tb_watchdog_reset_timer.sv
// Self-checking bench for the watchdog reset timer
`timescale 1ns/1ns
module tb_watchdog_reset_timer;
  import wdr_pkg::*;
  localparam logic [31:0] A_LO  = {22'h0, IDX_CNT_LO, 2'h0};
  localparam logic [31:0] A_HI  = {22'h0, IDX_CNT_HI, 2'h0};
  localparam logic [31:0] A_CTL = {22'h0, IDX_CTRL, 2'h0};
  localparam logic [31:0] A_ST  = {22'h0, IDX_STATUS, 2'h0};
  localparam logic [31:0] A_CMD = {22'h0, IDX_CMD, 2'h0};
  localparam logic [31:0] A_BAD = 32'h00000040;
  logic        hclk, hresetn, hsel, hwrite, ext_n, wake, halt;
  logic        hreadyout, hresp, wdt_reset, vector_load, stop_mode;
  logic [31:0] haddr, hwdata, hrdata, rv, sv;
  logic [1:0]  htrans;
  logic [15:0] restart_vector;
  int          bad_count, compares;
  wdr_watchdog DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_reset_pin_n(ext_n), .wake_pin(wake), .halt_mode(halt),
    .wdt_reset(wdt_reset), .vector_load(vector_load), .restart_vector(restart_vector), .stop_mode(stop_mode));
  always #5 hclk = ~hclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Called just after a rising edge; ready and read data are the values sampled at each rising edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rv);
  endtask : wr
  task automatic rd(input logic [31:0] a);
    bus(1'b0, a, WORD_ZERO, rv);
  endtask : rd
  task automatic s_reset;
    rd(A_HI); chk(rv, 32'hFF);
    rd(A_LO); chk(rv, 32'hFF);
    rd(A_ST); chk(rv, 32'h08);
    chk({16'h0, restart_vector}, WORD_ZERO);
  endtask : s_reset
  task automatic s_lock;
    wr(A_CTL, 32'h00);
    wr(A_CTL, 32'h71);
    rd(A_CTL); chk(rv, WORD_ZERO);
    wr(A_CMD, 32'h01);
    rd(A_HI); chk(rv, 32'h01);
    halt <= 1'b1;
    rd(A_ST); chk(rv, 32'h1C);
    halt <= 1'b0;
    wr(A_BAD, 32'hFF);
    rd(A_BAD); chk(rv, WORD_ZERO);
  endtask : s_lock
  task automatic s_timeout;
    int n;
    n = 0;
    wr(A_HI, 32'h00);
    wr(A_LO, 32'h03);
    while (wdt_reset !== 1'b1 && n < 400) begin
      @(negedge hclk);
      n++;
    end
    chk({31'h0, vector_load}, 32'h1);
    chk({31'h0, n >= 129 && n <= 192}, 32'h1);
    @(negedge hclk);
    chk({16'h0, restart_vector}, 32'h20);
    @(posedge hclk);
    rd(A_ST); chk(rv, 32'h0D);
    rd(A_ST); chk(rv, 32'h0D);
    wr(A_CMD, 32'h01);
    wr(A_ST, 32'h01);
    rd(A_ST); chk(rv, 32'h0C);
  endtask : s_timeout
  task automatic s_stop_pin;
    wr(A_CMD, 32'h02);
    @(negedge hclk);
    chk({31'h0, stop_mode}, 32'h1);
    @(posedge hclk);
    rd(A_LO);
    sv = rv;
    repeat (200) @(posedge hclk);
    rd(A_LO); chk(rv, sv);
    rd(A_ST); chk(rv & 32'h3, 32'h2);
    wake <= 1'b1;
    repeat (6) @(posedge hclk);
    chk({31'h0, stop_mode}, WORD_ZERO);
    wake <= 1'b0;
    ext_n <= 1'b0;
    repeat (8) @(posedge hclk);
    ext_n <= 1'b1;
    repeat (4) @(posedge hclk);
    rd(A_ST); chk(rv & 32'h7, 32'h4);
  endtask : s_stop_pin
  task results;
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  initial begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
    ext_n = 1; wake = 0; halt = 0; bad_count = 0; compares = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_reset;
    s_lock;
    s_timeout;
    s_stop_pin;
    results;
  end
  // Whole run needs well under 1500 cycles
  initial begin
    #60000;
    bad_count++;
    results;
  end
endmodule : tb_watchdog_reset_timer
